// file: core/hbrw_cfg.svh
// Constants for the host bus ready and wait handshake
`ifndef HBRW_CFG_SVH
`define HBRW_CFG_SVH

// Host address bus width and the lowest address bit that is decoded
`define HBRW_ADDR_W 16
`define HBRW_SEL_LSB 4

// Number of interrupt status bits gathered onto the interrupt pin
`define HBRW_IRQ_W 8

// System clock and fastest allowed bus clock, in MHz
`define HBRW_CLK_MHZ 25
`define HBRW_BCLK_MAX_MHZ 50

// Bus clock half period in system clock cycles, capped by the maximum rate
`define HBRW_BCLK_HALF_MIN \
  ((`HBRW_CLK_MHZ + 2 * `HBRW_BCLK_MAX_MHZ - 1) / (2 * `HBRW_BCLK_MAX_MHZ))
`define HBRW_BCLK_HALF 1

// System clock cycles the bus clock side stays in reset after release
`define HBRW_BRST_HOLD 8

// Default burst length in beats and mode code width
`define HBRW_BURST_BEATS 4
`define HBRW_BEAT_W 8
`define HBRW_MODE_W 2

`endif

// file: core/hbrw_pkg.sv
// Types shared by both ends of the host bus handshake
package hbrw_pkg;

  // Bus interface mode chosen by the strap at reset
  typedef enum logic [1:0] {
    HBRW_MODE_SYNC,
    HBRW_MODE_ASYNC,
    HBRW_MODE_BURST
  } hbrw_mode_t;

  // Device link-side states
  typedef enum logic [2:0] {
    HBRW_DS_IDLE,
    HBRW_DS_CMD,
    HBRW_DS_HOLD,
    HBRW_DS_BURST,
    HBRW_DS_END
  } hbrw_dev_state_t;

  // Host states
  typedef enum logic [2:0] {
    HBRW_HS_IDLE,
    HBRW_HS_ADDR,
    HBRW_HS_CMD,
    HBRW_HS_RET,
    HBRW_HS_BURST,
    HBRW_HS_END
  } hbrw_host_state_t;

endpackage

// file: core/hbrw_if.sv
// Pin-level link between the host end and the device end
`timescale 1ns/1ns
`include "hbrw_cfg.svh"
interface hbrw_if;
  logic bclk;
  logic [`HBRW_ADDR_W-1:0] host_addr;
  logic host_addr_enable;
  logic cycle_phase_n;
  logic host_write;
  logic host_ready_return_n;
  logic sync_mode_strap_n;
  logic sync_ready_out_n;
  logic irq_out_n_o;
  logic irq_out_n_oe_n;
  logic irq_out_n;
  logic local_device_select_n;

  // Open-drain interrupt line with its external pull-up
  assign irq_out_n = irq_out_n_oe_n ? 1'b1 : irq_out_n_o;

  modport dev (
    input bclk, host_addr, host_addr_enable, cycle_phase_n, host_write,
    input host_ready_return_n, sync_mode_strap_n,
    output sync_ready_out_n, irq_out_n_o, irq_out_n_oe_n,
    output local_device_select_n
  );

  modport host (
    output bclk, host_addr, host_addr_enable, cycle_phase_n, host_write,
    output host_ready_return_n, sync_mode_strap_n,
    input sync_ready_out_n, irq_out_n, local_device_select_n
  );
endinterface

// file: core/hbrw_host.sv
// Host end: bus clock maker and bus cycle driver
`timescale 1ns/1ns
`include "hbrw_cfg.svh"
module hbrw_host #(
  parameter int HALF = `HBRW_BCLK_HALF
) (
  hbrw_if.host link,
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sel_async,
  input wire logic async_clk_off,
  input wire logic req,
  input wire logic req_write,
  input wire logic [`HBRW_ADDR_W-1:0] req_addr,
  input wire logic [`HBRW_BEAT_W-1:0] req_beats,
  input wire logic host_stall,
  input wire logic burst_mode,
  output logic busy,
  output logic done,
  output logic irq_seen
);
  logic [7:0] div_q, div_d;
  logic bclk_q, bclk_d;
  logic step;
  logic srdy_m_q, srdy_s_q, irq_m_q, irq_s_q;
  hbrw_pkg::hbrw_host_state_t st_q, st_d;
  logic [`HBRW_ADDR_W-1:0] addr_q, addr_d;
  logic aen_q, aen_d, cyc_q, cyc_d, wr_q, wr_d, rrn_q, rrn_d;
  logic strap_q, strap_d, done_q, done_d;
  logic [`HBRW_BEAT_W-1:0] beats_q, beats_d;

  // Bus clock divider, held low while async_clk_off is set
  always_comb begin
    div_d = div_q;
    bclk_d = bclk_q;
    step = 1'b0;
    if (async_clk_off) begin // R4
      div_d = 8'h00;
      bclk_d = 1'b0;
    end else if (div_q == 8'(HALF - 1)) begin // R3
      div_d = 8'h00;
      bclk_d = ~bclk_q;
      step = bclk_q;
    end else begin
      div_d = div_q + 8'h01;
    end
  end

  // Bus cycle sequencer, leaving idle on a request and otherwise advancing on falling bus clock edges
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    aen_d = aen_q;
    cyc_d = cyc_q;
    wr_d = wr_q;
    rrn_d = rrn_q;
    beats_d = beats_q;
    done_d = 1'b0;
    strap_d = sel_async;
    if (st_q == hbrw_pkg::HBRW_HS_IDLE && req) begin
      st_d = hbrw_pkg::HBRW_HS_ADDR;
      addr_d = req_addr;
      wr_d = req_write;
      beats_d = req_beats;
    end else if (step) begin
      case (st_q)
        hbrw_pkg::HBRW_HS_ADDR: begin
          aen_d = 1'b0;
          if (burst_mode) begin
            cyc_d = ~wr_q; // R10
            st_d = hbrw_pkg::HBRW_HS_BURST;
          end else if (!aen_q) begin
            // Command phase one bus clock after the address phase
            cyc_d = 1'b0; // R11
            st_d = hbrw_pkg::HBRW_HS_CMD;
          end
        end
        hbrw_pkg::HBRW_HS_CMD: begin
          if (!srdy_s_q) begin
            if (wr_q) begin
              st_d = hbrw_pkg::HBRW_HS_END;
            end else begin
              rrn_d = 1'b0; // R1
              st_d = hbrw_pkg::HBRW_HS_RET;
            end
          end
        end
        hbrw_pkg::HBRW_HS_RET: begin
          if (srdy_s_q) begin
            rrn_d = 1'b1;
            st_d = hbrw_pkg::HBRW_HS_END;
          end
        end
        hbrw_pkg::HBRW_HS_BURST: begin
          rrn_d = ~host_stall; // R2
          if (srdy_s_q && rrn_q) begin
            if (beats_q <= 8'h01) begin
              st_d = hbrw_pkg::HBRW_HS_END;
            end else begin
              beats_d = beats_q - 8'h01;
            end
          end
        end
        hbrw_pkg::HBRW_HS_END: begin
          aen_d = 1'b1;
          cyc_d = 1'b1;
          rrn_d = 1'b1;
          done_d = 1'b1;
          st_d = hbrw_pkg::HBRW_HS_IDLE;
        end
        default: st_d = hbrw_pkg::HBRW_HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    srdy_m_q <= link.sync_ready_out_n;
    srdy_s_q <= srdy_m_q;
    irq_m_q <= link.irq_out_n;
    irq_s_q <= irq_m_q;
    // Strap is a pin level, live during reset so it can be captured
    strap_q <= strap_d;
    if (sys_rst) begin
      div_q <= 8'h00;
      bclk_q <= 1'b0;
      st_q <= hbrw_pkg::HBRW_HS_IDLE;
      addr_q <= '0;
      aen_q <= 1'b1;
      cyc_q <= 1'b1;
      wr_q <= 1'b0;
      rrn_q <= 1'b1;
      beats_q <= '0;
      done_q <= 1'b0;
      irq_seen <= 1'b0;
    end else begin
      div_q <= div_d;
      bclk_q <= bclk_d;
      st_q <= st_d;
      addr_q <= addr_d;
      aen_q <= aen_d;
      cyc_q <= cyc_d;
      wr_q <= wr_d;
      rrn_q <= rrn_d;
      beats_q <= beats_d;
      done_q <= done_d;
      irq_seen <= ~irq_s_q;
    end
  end

  assign link.bclk = bclk_q;
  assign link.host_addr = addr_q;
  assign link.host_addr_enable = aen_q;
  assign link.cycle_phase_n = cyc_q;
  assign link.host_write = wr_q;
  assign link.host_ready_return_n = rrn_q;
  assign link.sync_mode_strap_n = strap_q;
  assign busy = (st_q != hbrw_pkg::HBRW_HS_IDLE);
  assign done = done_q;
endmodule

// file: core/hbrw_device.sv
// Device end: ready and wait output, interrupt pin and device select
// How it works
// R1: Host returns ready to end sync reads
// R2: Host drives return low for burst waits
// R3: Host bus clock at most 50 MHz
// R4: Host holds bus clock low when asynchronous
// R5: Sync ready output extends burst and sync accesses
// R6: Sync ready falls on bus clock edge
// R7: Burst wait states drive sync ready low
// R8: Interrupt pin low while any status set
// R9: Strap low selects sync, high others
// R10: Burst cycle input high read, low write
// R11: Cycle input marks command after addressing
// R12: Device select decodes address and enable
// R13: Ready return sampled on bus clock rises
`timescale 1ns/1ns
`include "hbrw_cfg.svh"
module hbrw_device #(
  parameter int IRQ_W = `HBRW_IRQ_W,
  parameter bit BUS32 = 1'b1
) (
  hbrw_if.dev link,
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`HBRW_ADDR_W-1:0] base_addr,
  input wire logic core_ready,
  input wire logic [IRQ_W-1:0] irq_status,
  output logic xfer_done,
  output logic xfer_write,
  output var hbrw_pkg::hbrw_mode_t bus_mode
);

  // System clock domain
  logic [3:0] bhold_q, bhold_d;
  logic breq_q, breq_d;
  logic strap_m_q, strap_s_q;
  logic cap_q, cap_d;
  hbrw_pkg::hbrw_mode_t mode_q, mode_d;
  logic irq_oe_n_q, irq_oe_n_d;
  logic tgl_m_q, tgl_s_q, tgl_p_q;
  logic done_q, done_d;
  logic wr_q, wr_d;

  // Bus clock domain
  logic brst_m_q, brst_s_q;
  logic [`HBRW_MODE_W-1:0] bmode_m_q, bmode_s_q;
  hbrw_pkg::hbrw_mode_t bmode;
  logic rdy_m_q, rdy_s_q;
  hbrw_pkg::hbrw_dev_state_t st_q, st_d;
  logic srdy_q, srdy_d;
  logic tgl_q, tgl_d;
  logic bwr_q, bwr_d;
  logic sel_n;

  // Mode captured once after reset from the synchronised strap
  always_comb begin
    cap_d = 1'b1;
    mode_d = mode_q;
    if (!cap_q) begin
      if (!strap_s_q) begin // R9
        mode_d = hbrw_pkg::HBRW_MODE_SYNC;
      end else if (BUS32) begin
        mode_d = hbrw_pkg::HBRW_MODE_BURST;
      end else begin
        mode_d = hbrw_pkg::HBRW_MODE_ASYNC;
      end
    end
  end

  // Bus clock is held during reset, so its side is reset after release
  always_comb begin
    bhold_d = bhold_q;
    breq_d = 1'b0;
    if (bhold_q != 4'h0) begin
      bhold_d = bhold_q - 4'h1;
      breq_d = 1'b1;
    end
  end

  // Interrupt pin pulled low by any pending status bit
  always_comb begin
    irq_oe_n_d = ~(|irq_status); // R8
  end

  // Completed transfer seen as a toggle from the bus clock side
  always_comb begin
    done_d = 1'b0;
    wr_d = wr_q;
    if (tgl_s_q != tgl_p_q) begin
      done_d = 1'b1;
      wr_d = bwr_q;
    end
  end

  // Strap synchroniser holds no reset so it is valid at release
  always_ff @(posedge clk) begin
    strap_m_q <= link.sync_mode_strap_n;
    strap_s_q <= strap_m_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cap_q <= 1'b0;
      bhold_q <= 4'(`HBRW_BRST_HOLD);
      breq_q <= 1'b1;
      mode_q <= hbrw_pkg::HBRW_MODE_SYNC;
      irq_oe_n_q <= 1'b1;
      tgl_m_q <= 1'b0;
      tgl_s_q <= 1'b0;
      tgl_p_q <= 1'b0;
      done_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      cap_q <= cap_d;
      bhold_q <= bhold_d;
      breq_q <= breq_d;
      mode_q <= mode_d;
      irq_oe_n_q <= irq_oe_n_d;
      tgl_m_q <= tgl_q;
      tgl_s_q <= tgl_m_q;
      tgl_p_q <= tgl_s_q;
      done_q <= done_d;
      wr_q <= wr_d;
    end
  end

  assign xfer_done = done_q;
  assign xfer_write = wr_q;
  assign bus_mode = mode_q;
  assign link.irq_out_n_o = 1'b0;
  assign link.irq_out_n_oe_n = irq_oe_n_q;

  // Device select is a pure decode of address and enable
  always_comb begin
    sel_n = 1'b1;
    if (!link.host_addr_enable &&
        link.host_addr[`HBRW_ADDR_W-1:`HBRW_SEL_LSB] ==
        base_addr[`HBRW_ADDR_W-1:`HBRW_SEL_LSB]) begin
      sel_n = 1'b0; // R12
    end
  end
  assign link.local_device_select_n = sel_n;

  // Reset, mode and core readiness brought onto the bus clock
  always_ff @(posedge link.bclk) begin
    brst_m_q <= breq_q;
    brst_s_q <= brst_m_q;
    bmode_m_q <= mode_q;
    bmode_s_q <= bmode_m_q;
    rdy_m_q <= core_ready;
    rdy_s_q <= rdy_m_q;
  end
  assign bmode = hbrw_pkg::hbrw_mode_t'(bmode_s_q);

  // Ready and wait sequencer on the bus clock
  always_comb begin
    st_d = st_q;
    srdy_d = srdy_q;
    tgl_d = tgl_q;
    bwr_d = bwr_q;
    case (st_q)
      hbrw_pkg::HBRW_DS_IDLE: begin
        srdy_d = 1'b1;
        if (!sel_n && bmode == hbrw_pkg::HBRW_MODE_SYNC &&
            !link.cycle_phase_n) begin
          bwr_d = link.host_write;
          st_d = hbrw_pkg::HBRW_DS_CMD;
        end else if (!sel_n && bmode == hbrw_pkg::HBRW_MODE_BURST) begin
          bwr_d = ~link.cycle_phase_n; // R10
          srdy_d = rdy_s_q; // R7
          st_d = hbrw_pkg::HBRW_DS_BURST;
        end
      end
      hbrw_pkg::HBRW_DS_CMD: begin
        if (rdy_s_q) begin
          srdy_d = 1'b0; // R6
          if (bwr_q) begin
            tgl_d = ~tgl_q;
            st_d = hbrw_pkg::HBRW_DS_END;
          end else begin
            st_d = hbrw_pkg::HBRW_DS_HOLD;
          end
        end
      end
      hbrw_pkg::HBRW_DS_HOLD: begin
        if (!link.host_ready_return_n) begin // R13
          srdy_d = 1'b1; // R5
          tgl_d = ~tgl_q;
          st_d = hbrw_pkg::HBRW_DS_END;
        end
      end
      hbrw_pkg::HBRW_DS_BURST: begin
        if (sel_n) begin
          srdy_d = 1'b1;
          st_d = hbrw_pkg::HBRW_DS_IDLE;
        end else begin
          srdy_d = rdy_s_q; // R7
          if (srdy_q && link.host_ready_return_n) begin // R2
            tgl_d = ~tgl_q;
          end
        end
      end
      hbrw_pkg::HBRW_DS_END: begin
        srdy_d = 1'b1;
        if (link.cycle_phase_n) begin
          st_d = hbrw_pkg::HBRW_DS_IDLE;
        end
      end
      default: st_d = hbrw_pkg::HBRW_DS_IDLE;
    endcase
  end

  always_ff @(posedge link.bclk) begin
    if (brst_s_q) begin
      st_q <= hbrw_pkg::HBRW_DS_IDLE;
      srdy_q <= 1'b1;
      tgl_q <= 1'b0;
      bwr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      srdy_q <= srdy_d; // R6
      tgl_q <= tgl_d;
      bwr_q <= bwr_d;
    end
  end

  assign link.sync_ready_out_n = srdy_q; // R5

endmodule

// file: verification/hbrw_link_sva.sv
// Checker of the handshake pins between host and device ends
`timescale 1ns/1ns
`include "hbrw_cfg.svh"
module hbrw_link_sva #(
  parameter int IRQ_W = `HBRW_IRQ_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic bclk,
  input wire logic [`HBRW_ADDR_W-1:0] host_addr,
  input wire logic host_addr_enable,
  input wire logic cycle_phase_n,
  input wire logic host_write,
  input wire logic host_ready_return_n,
  input wire logic sync_mode_strap_n,
  input wire logic sync_ready_out_n,
  input wire logic irq_out_n,
  input wire logic local_device_select_n,
  input wire logic [`HBRW_ADDR_W-1:0] base_addr,
  input wire logic [IRQ_W-1:0] irq_status
);
  localparam int HI = `HBRW_ADDR_W - 1;
  localparam int LO = `HBRW_SEL_LSB;

  property p_dev_sel;
    @(posedge clk) disable iff (sys_rst) local_device_select_n ==
      !(!host_addr_enable && host_addr[HI:LO] == base_addr[HI:LO]);
  endproperty
  a_dev_sel: assert property (p_dev_sel) else $error("bad select");
  property p_irq_on;
    @(posedge clk) disable iff (sys_rst) (|irq_status) |=> !irq_out_n;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq not low");
  property p_irq_off;
    @(posedge clk) disable iff (sys_rst) !(|irq_status) |=> irq_out_n;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq not off");
  property p_srdy_step;
    @(posedge clk) disable iff (sys_rst)
      $changed(sync_ready_out_n) |-> bclk;
  endproperty
  a_srdy_step: assert property (p_srdy_step) else $error("srdy off");
  property p_read_end;
    @(posedge bclk) disable iff (sys_rst) !sync_mode_strap_n && !host_write
      && !cycle_phase_n && !sync_ready_out_n && !host_ready_return_n
      |=> sync_ready_out_n;
  endproperty
  a_read_end: assert property (p_read_end) else $error("no end");
  property p_srdy_fall;
    @(posedge bclk) disable iff (sys_rst)
      !sync_mode_strap_n && $fell(sync_ready_out_n) |-> !$past(cycle_phase_n);
  endproperty
  a_srdy_fall: assert property (p_srdy_fall) else $error("early rdy");
  property p_burst_end;
    @(posedge bclk) disable iff (sys_rst)
      (sync_mode_strap_n && local_device_select_n) [*2]
      |-> ##[0:1] sync_ready_out_n;
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("srdy low");
  property p_burst_dir;
    @(posedge bclk) disable iff (sys_rst) sync_mode_strap_n
      && !host_addr_enable && !$past(host_addr_enable)
      |-> cycle_phase_n == !host_write;
  endproperty
  a_burst_dir: assert property (p_burst_dir) else $error("bad dir");
  property p_cmd_order;
    @(posedge bclk) disable iff (sys_rst) !sync_mode_strap_n
      && $fell(cycle_phase_n) |-> !$past(host_addr_enable) && !host_addr_enable;
  endproperty
  a_cmd_order: assert property (p_cmd_order) else $error("bad cmd");
  c_read: cover property (@(posedge bclk) !host_write && !host_ready_return_n);
  c_wait: cover property (@(posedge bclk) sync_mode_strap_n
    && !local_device_select_n && !sync_ready_out_n);
  c_irq: cover property (@(posedge clk) $fell(irq_out_n));
endmodule

// file: verification/host_bus_ready_wait_handshake_tb.sv
// Bench joining the host end and the device end
`timescale 1ns/1ns
`include "hbrw_cfg.svh"
module host_bus_ready_wait_handshake_tb;
  localparam logic [15:0] BASE = 16'h3A50;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sel_async = 1'b0;
  logic async_clk_off = 1'b0;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic [15:0] req_addr = 16'h0000;
  logic [7:0] req_beats = 8'h01;
  logic host_stall = 1'b0;
  logic burst_mode = 1'b0;
  logic core_ready = 1'b1;
  logic [`HBRW_IRQ_W-1:0] irq_status = 8'h00;
  logic busy, done, irq_seen, xfer_done, xfer_write;
  hbrw_pkg::hbrw_mode_t bus_mode;
  int err_count = 0;
  int n_checks = 0;
  int beats = 0;
  int i;

  always #20 clk = ~clk;
  always @(posedge clk) if (xfer_done === 1'b1) beats <= beats + 1;

  hbrw_if link ();
  hbrw_host hbrw_host_inst (.link(link), .clk(clk), .sys_rst(sys_rst),
    .sel_async(sel_async), .async_clk_off(async_clk_off), .req(req),
    .req_write(req_write), .req_addr(req_addr), .req_beats(req_beats),
    .host_stall(host_stall), .burst_mode(burst_mode), .busy(busy),
    .done(done), .irq_seen(irq_seen));
  hbrw_device hbrw_device_inst (.link(link), .clk(clk), .sys_rst(sys_rst),
    .base_addr(BASE), .core_ready(core_ready), .irq_status(irq_status),
    .xfer_done(xfer_done), .xfer_write(xfer_write), .bus_mode(bus_mode));
  hbrw_link_sva #(.IRQ_W(`HBRW_IRQ_W)) hbrw_link_sva_inst (.clk(clk),
    .sys_rst(sys_rst), .bclk(link.bclk), .host_addr(link.host_addr),
    .host_addr_enable(link.host_addr_enable),
    .cycle_phase_n(link.cycle_phase_n), .host_write(link.host_write),
    .host_ready_return_n(link.host_ready_return_n),
    .sync_mode_strap_n(link.sync_mode_strap_n),
    .sync_ready_out_n(link.sync_ready_out_n), .irq_out_n(link.irq_out_n),
    .local_device_select_n(link.local_device_select_n),
    .base_addr(BASE), .irq_status(irq_status));

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic strap);
    sys_rst = 1'b1;
    sel_async = strap;
    burst_mode = strap;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    repeat (16) @(negedge clk);
  endtask

  // One host cycle, then a settling gap for late beat pulses
  task automatic xfer(input logic wr, input logic [7:0] n);
    int t;
    @(negedge clk);
    beats = 0;
    req = 1'b1;
    req_write = wr;
    req_addr = BASE | 16'h000C;
    req_beats = n;
    @(negedge clk);
    req = 1'b0;
    chk("busy", 16'h0001, {15'h0000, busy});
    t = 0;
    while (done !== 1'b1 && t < 3000) begin
      @(negedge clk);
      t++;
    end
    if (t >= 3000) begin
      err_count++;
    end
    repeat (8) @(negedge clk);
  endtask

  // Runs a cycle while the far party holds it back
  task automatic held(input logic wr, input logic [7:0] n);
    fork
      xfer(wr, n);
      begin
        repeat (40) @(negedge clk);
        chk("held beats", 16'h0000, 16'(beats));
        chk("held busy", 16'h0001, {15'h0000, busy});
        if (burst_mode && !host_stall) begin
          chk("wait", 16'h0000, {15'h0000, link.sync_ready_out_n});
        end
        core_ready = 1'b1;
        host_stall = 1'b0;
      end
    join
  endtask

  initial begin
    do_reset(1'b0);
    chk("mode", 16'(hbrw_pkg::HBRW_MODE_SYNC), 16'(bus_mode));
    for (i = 0; i < 2; i++) begin
      xfer(i[0], 8'h01);
      chk("beats", 16'h0001, 16'(beats));
      chk("dir", {15'h0000, i[0]}, {15'h0000, xfer_write});
    end
    core_ready = 1'b0;
    held(1'b0, 8'h01);
    chk("beats", 16'h0001, 16'(beats));
    for (i = 0; i < 8; i++) begin
      irq_status = 8'h01 << i;
      repeat (6) @(negedge clk);
      chk("irq", 16'h0000, {15'h0000, link.irq_out_n});
      chk("irq_seen", 16'h0001, {15'h0000, irq_seen});
      irq_status = 8'h00;
      repeat (6) @(negedge clk);
      chk("irq", 16'h0001, {15'h0000, link.irq_out_n});
      chk("irq_seen", 16'h0000, {15'h0000, irq_seen});
    end
    async_clk_off = 1'b1;
    repeat (4) @(negedge clk);
    for (i = 0; i < 4; i++) begin
      @(negedge clk);
      chk("bclk", 16'h0000, {15'h0000, link.bclk});
    end
    async_clk_off = 1'b0;
    do_reset(1'b1);
    chk("mode", 16'(hbrw_pkg::HBRW_MODE_BURST), 16'(bus_mode));
    host_stall = 1'b1;
    held(1'b1, 8'h04);
    chk("burst dir", 16'h0001, {15'h0000, xfer_write});
    chk("burst beats", 16'h0001, 16'(beats != 0));
    core_ready = 1'b0;
    held(1'b0, 8'h02);
    chk("burst dir", 16'h0000, {15'h0000, xfer_write});
    tally_and_finish();
  end
endmodule
